// *** design/gpio_consts.svh ***
// Register offsets, field positions, masks and reset values of the GPIO block
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// Input and output register spaces, one address per port
`define GPIO_PORT_A_IO_ADDR 8'h00
`define GPIO_PORT_B_IO_ADDR 8'h01
`define GPIO_PORT_C_IO_ADDR 8'h02

// Configuration register space, four registers per port
`define GPIO_PORT_A_PULLUP_ADDR 8'h18
`define GPIO_PORT_A_OPTION_ADDR 8'h19
`define GPIO_PORT_A_DIRECTION_ADDR 8'h1A
`define GPIO_PORT_A_ALT_FUNCTION_ADDR 8'h1B
`define GPIO_PORT_B_PULLUP_ADDR 8'h1C
`define GPIO_PORT_B_OPTION_ADDR 8'h1D
`define GPIO_PORT_B_DIRECTION_ADDR 8'h1E
`define GPIO_PORT_B_ALT_FUNCTION_ADDR 8'h1F
`define GPIO_PORT_C_PULLUP_ADDR 8'h20
`define GPIO_PORT_C_OPTION_ADDR 8'h21
`define GPIO_PORT_C_DIRECTION_ADDR 8'h22
`define GPIO_PORT_C_ALT_FUNCTION_ADDR 8'h23
`define GPIO_CFG_FIRST_ADDR 8'h18
`define GPIO_CFG_LAST_ADDR 8'h23

// Field position of a register inside a port's group of four
`define GPIO_FIELD_PULLUP 2'h0
`define GPIO_FIELD_OPTION 2'h1
`define GPIO_FIELD_DIRECTION 2'h2
`define GPIO_FIELD_ALT_FUNCTION 2'h3

// Implemented pins per port and reset values
`define GPIO_FULL_PORT_MASK 8'hFF
`define GPIO_PORT_C_MASK 8'h3F
`define GPIO_CFG_RESET 8'h00
`define GPIO_OUT_RESET 8'h00

// Package variants
`define GPIO_VARIANT_16_PIN 2
`define GPIO_VARIANT_20_PIN 1
`define GPIO_VARIANT_FULL 0

`endif

// *** design/gpio_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`include "gpio_consts.svh"

module gpio_pin_sync #(
   parameter int unsigned WIDTH = 8
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Raw pins and filtered levels
   input wire logic [WIDTH-1:0] pin_raw,
   output logic [WIDTH-1:0] pin_level
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_q;

   // Stage one is read by stage two alone, to keep metastability contained
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
      end
      else
      begin
         stage1_q <= pin_raw;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // A bit changes only once the two settled stages agree
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         level_q <= '0;
      else
         level_q <= (stage2_q & stage3_q) | (level_q & (stage2_q | stage3_q));
   end

   assign pin_level = level_q;

endmodule

// *** design/gpio_pkg.sv ***
// Types shared by the GPIO block
package gpio_pkg;

   // Pin mode from the pull-up, option and direction bits
   typedef enum logic [2:0] {
      MODE_INPUT_HIZ = 3'h0,
      MODE_OUTPUT_PUSH_PULL = 3'h1,
      MODE_INTERRUPT_NO_PULLUP = 3'h2,
      MODE_OUTPUT_OPEN_DRAIN = 3'h3,
      MODE_INPUT_PULLUP = 3'h4,
      MODE_OUTPUT_PULLUP = 3'h5,
      MODE_INTERRUPT_PULLUP = 3'h6,
      MODE_OUTPUT_WEAK_PULLUP = 3'h7
   } pin_mode_type;

   typedef logic [7:0] port_byte_type;

endpackage

// *** design/three_port_gpio_config.sv ***
// Three-port GPIO block: configuration, input and output registers, pin drive
// Overview of operation
// - Port B direction bit: 0 input, 1 output
// - Port C has pins 5..0 only
// - Port B alternate bit selects analog channel
// - Port C alternate bit routes pin to peripheral
// - Port C pull-up bit enables pull-up
// - Port C option bit per pin 5..0
// - Configuration registers read/write, reset to zero
// - Input register returns digital input levels
// - Input registers read-only, follow pins
// - Output register drives pins set as outputs
// - Output registers write-only, reset to zero
// - Smaller packages leave some registers unused
// - Pull-up, option, direction decode pin mode
// - Pull-up and option latch on direction write
// - Output pins read back the output latch
// - Interrupt pins ORed per port on ports A and B only, edge selectable
`timescale 1ns/10ps
`include "gpio_consts.svh"

module three_port_gpio_config
   import gpio_pkg::*;
#(
   parameter int unsigned PKG_VARIANT = `GPIO_VARIANT_FULL
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Configuration register space
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_rd,
   output logic [7:0] cfg_rdata,
   // Input register space
   input wire logic [7:0] in_addr,
   input wire logic in_rd,
   output logic [7:0] in_rdata,
   // Output register space
   input wire logic [7:0] out_addr,
   input wire logic out_wr,
   input wire logic [7:0] out_wdata,
   // Port A pins
   input wire logic [7:0] port_a_pin_in,
   output logic [7:0] port_a_pin_out,
   output logic [7:0] port_a_pin_oe,
   output logic [7:0] port_a_pin_pullup,
   // Port B pins
   input wire logic [7:0] port_b_pin_in,
   output logic [7:0] port_b_pin_out,
   output logic [7:0] port_b_pin_oe,
   output logic [7:0] port_b_pin_pullup,
   // Port C pins
   input wire logic [5:0] port_c_pin_in,
   output logic [5:0] port_c_pin_out,
   output logic [5:0] port_c_pin_oe,
   output logic [5:0] port_c_pin_pullup,
   // Peripheral side of the alternate functions
   input wire logic [7:0] port_a_periph_out,
   output logic [7:0] port_a_periph_in,
   input wire logic [5:0] port_c_periph_out,
   output logic [5:0] port_c_periph_in,
   output logic [7:0] analog_input_channel,
   output logic analog_vref_select,
   // Port interrupt requests
   input wire logic port_a_irq_rising,
   input wire logic port_b_irq_rising,
   output logic port_a_irq,
   output logic port_b_irq
);

   localparam int NPORTS = 3;

   // Configuration state: written values and the active copies
   port_byte_type pu_q [NPORTS];
   port_byte_type or_q [NPORTS];
   port_byte_type pu_act_q [NPORTS];
   port_byte_type or_act_q [NPORTS];
   port_byte_type ddr_q [NPORTS];
   port_byte_type af_q [NPORTS];
   port_byte_type out_q [NPORTS];
   port_byte_type level [NPORTS];
   port_byte_type periph_drv [NPORTS];
   port_byte_type pin_out_d [NPORTS];
   port_byte_type pin_oe_d [NPORTS];
   port_byte_type pin_pu_d [NPORTS];
   port_byte_type pin_out_q [NPORTS];
   port_byte_type pin_oe_q [NPORTS];
   port_byte_type pin_pu_q [NPORTS];
   port_byte_type readback [NPORTS];
   logic [7:0] cfg_rdata_q;
   logic [7:0] cfg_rdata_d;
   logic [7:0] in_rdata_q;
   logic [7:0] in_rdata_d;
   logic [7:0] cfg_index;
   logic [1:0] cfg_port;
   logic [1:0] cfg_field;
   logic cfg_hit;
   logic [7:0] port_a_level;
   logic [7:0] port_b_level;
   logic [5:0] port_c_level;
   logic [7:0] periph_a_q;
   logic [5:0] periph_c_q;
   logic [7:0] analog_q;
   logic vref_q;
   logic [1:0] irq_or_d;
   logic [1:0] irq_or_q;
   logic [1:0] irq_q;

   // Implemented bits of a register, given port, field and package variant
   function automatic port_byte_type reg_mask(input int p, input int f);
      port_byte_type m;
      m = (p == 2) ? `GPIO_PORT_C_MASK : `GPIO_FULL_PORT_MASK;
      if (p == 2 && PKG_VARIANT != `GPIO_VARIANT_FULL)
         m = `GPIO_CFG_RESET;
      else if (p == 1 && f == 3 && PKG_VARIANT == `GPIO_VARIANT_16_PIN)
         m = `GPIO_CFG_RESET;
      return m;
   endfunction

   // Every pin level goes through the synchroniser first
   gpio_pin_sync #(.WIDTH(8)) sync_a (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_raw(port_a_pin_in),
      .pin_level(port_a_level)
   );
   gpio_pin_sync #(.WIDTH(8)) sync_b (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_raw(port_b_pin_in),
      .pin_level(port_b_level)
   );
   gpio_pin_sync #(.WIDTH(6)) sync_c (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_raw(port_c_pin_in),
      .pin_level(port_c_level)
   );

   // Widen ports to bytes; unimplemented bits sit at zero
   assign level[0] = port_a_level;
   assign level[1] = port_b_level;
   assign level[2] = {2'h0, port_c_level};
   assign periph_drv[0] = port_a_periph_out;
   assign periph_drv[1] = 8'h00;
   assign periph_drv[2] = {2'h0, port_c_periph_out};

   // Configuration address decode
   always_comb
   begin
      cfg_index = cfg_addr - `GPIO_CFG_FIRST_ADDR;
      cfg_port = cfg_index[3:2];
      cfg_field = cfg_index[1:0];
      if (cfg_addr < `GPIO_CFG_FIRST_ADDR)
         cfg_hit = 1'b0;
      else if (cfg_addr > `GPIO_CFG_LAST_ADDR)
         cfg_hit = 1'b0;
      else
         cfg_hit = 1'b1;
   end

   // Configuration registers; pull-up and option go live on a direction write
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < NPORTS; p++)
         begin
            pu_q[p] <= `GPIO_CFG_RESET;
            or_q[p] <= `GPIO_CFG_RESET;
            pu_act_q[p] <= `GPIO_CFG_RESET;
            or_act_q[p] <= `GPIO_CFG_RESET;
            ddr_q[p] <= `GPIO_CFG_RESET;
            af_q[p] <= `GPIO_CFG_RESET;
         end
      end
      else if (cfg_wr && cfg_hit)
      begin
         for (int p = 0; p < NPORTS; p++)
         begin
            if (cfg_port == 2'(p))
            begin
               if (cfg_field == `GPIO_FIELD_PULLUP)
                  pu_q[p] <= cfg_wdata & reg_mask(p, 0);
               else if (cfg_field == `GPIO_FIELD_OPTION)
                  or_q[p] <= cfg_wdata & reg_mask(p, 1);
               else if (cfg_field == `GPIO_FIELD_DIRECTION)
               begin
                  ddr_q[p] <= cfg_wdata & reg_mask(p, 2);
                  pu_act_q[p] <= pu_q[p];
                  or_act_q[p] <= or_q[p];
               end
               else
                  af_q[p] <= cfg_wdata & reg_mask(p, 3);
            end
         end
      end
   end

   // Configuration read data, held until the next read
   always_comb
   begin
      cfg_rdata_d = cfg_rdata_q;
      if (cfg_rd)
      begin
         cfg_rdata_d = 8'h00;
         for (int p = 0; p < NPORTS; p++)
         begin
            if (cfg_hit && cfg_port == 2'(p))
            begin
               if (cfg_field == `GPIO_FIELD_PULLUP)
                  cfg_rdata_d = pu_q[p];
               else if (cfg_field == `GPIO_FIELD_OPTION)
                  cfg_rdata_d = or_q[p];
               else if (cfg_field == `GPIO_FIELD_DIRECTION)
                  cfg_rdata_d = ddr_q[p];
               else
                  cfg_rdata_d = af_q[p];
            end
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         cfg_rdata_q <= 8'h00;
      else
         cfg_rdata_q <= cfg_rdata_d;
   end

   // Output latches; the output space has no read path
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < NPORTS; p++)
            out_q[p] <= `GPIO_OUT_RESET;
      end
      else if (out_wr)
      begin
         if (out_addr == `GPIO_PORT_A_IO_ADDR)
            out_q[0] <= out_wdata & reg_mask(0, 0);
         else if (out_addr == `GPIO_PORT_B_IO_ADDR)
            out_q[1] <= out_wdata & reg_mask(1, 0);
         else if (out_addr == `GPIO_PORT_C_IO_ADDR)
            out_q[2] <= out_wdata & reg_mask(2, 0);
      end
   end

   // Input view: pin level for inputs, output latch for outputs
   always_comb
   begin
      for (int p = 0; p < NPORTS; p++)
         readback[p] = ((ddr_q[p] & out_q[p]) | (~ddr_q[p] & level[p])) & reg_mask(p, 0);
   end

   // Input registers are read-only and track the pins; read data is held until the next read and resets to zero
   always_comb
   begin
      in_rdata_d = in_rdata_q;
      if (in_rd)
      begin
         if (in_addr == `GPIO_PORT_A_IO_ADDR)
            in_rdata_d = readback[0];
         else if (in_addr == `GPIO_PORT_B_IO_ADDR)
            in_rdata_d = readback[1];
         else if (in_addr == `GPIO_PORT_C_IO_ADDR)
            in_rdata_d = readback[2];
         else
            in_rdata_d = 8'h00;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         in_rdata_q <= 8'h00;
      else
         in_rdata_q <= in_rdata_d;
   end

   // Pin drive per mode; port B alternate releases the pin to the analog path
   always_comb
   begin
      for (int p = 0; p < NPORTS; p++)
      begin
         for (int n = 0; n < 8; n++)
         begin
            logic data;
            pin_mode_type mode;
            data = (af_q[p][n] && p != 1) ? periph_drv[p][n] : out_q[p][n];
            mode = pin_mode_type'({pu_act_q[p][n], or_act_q[p][n], ddr_q[p][n]});
            pin_out_d[p][n] = 1'b0;
            pin_oe_d[p][n] = 1'b0;
            pin_pu_d[p][n] = 1'b0;
            if (p == 1 && af_q[p][n])
               pin_pu_d[p][n] = 1'b0;
            else
            begin
               case (mode)
                  MODE_OUTPUT_PUSH_PULL:
                  begin
                     pin_out_d[p][n] = data;
                     pin_oe_d[p][n] = 1'b1;
                  end
                  MODE_OUTPUT_PULLUP:
                  begin
                     pin_out_d[p][n] = data;
                     pin_oe_d[p][n] = 1'b1;
                     pin_pu_d[p][n] = 1'b1;
                  end
                  MODE_OUTPUT_OPEN_DRAIN:
                     pin_oe_d[p][n] = ~data;
                  MODE_OUTPUT_WEAK_PULLUP:
                  begin
                     pin_oe_d[p][n] = ~data;
                     pin_pu_d[p][n] = 1'b1;
                  end
                  MODE_INPUT_PULLUP, MODE_INTERRUPT_PULLUP:
                     pin_pu_d[p][n] = 1'b1;
                  default:
                     pin_pu_d[p][n] = 1'b0;
               endcase
            end
         end
         pin_out_d[p] = pin_out_d[p] & reg_mask(p, 0);
         pin_oe_d[p] = pin_oe_d[p] & reg_mask(p, 0);
         pin_pu_d[p] = pin_pu_d[p] & reg_mask(p, 0);
      end
   end

   // Registered pin drive so every pin output comes from a flop
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < NPORTS; p++)
         begin
            pin_out_q[p] <= 8'h00;
            pin_oe_q[p] <= 8'h00;
            pin_pu_q[p] <= 8'h00;
         end
      end
      else
      begin
         pin_out_q <= pin_out_d;
         pin_oe_q <= pin_oe_d;
         pin_pu_q <= pin_pu_d;
      end
   end

   // Alternate-function routing towards peripherals and the converter
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         periph_a_q <= 8'h00;
         periph_c_q <= 6'h00;
         analog_q <= 8'h00;
         vref_q <= 1'b0;
      end
      else
      begin
         periph_a_q <= level[0] & af_q[0];
         periph_c_q <= port_c_level & af_q[2][5:0];
         analog_q <= af_q[1];
         vref_q <= af_q[1][0];
      end
   end

   // Interrupt pins ORed per port, ports A and B only; only the chosen edge of the OR requests
   always_comb
   begin
      for (int p = 0; p < 2; p++)
         irq_or_d[p] = |(level[p] & or_act_q[p] & ~ddr_q[p] & ~af_q[p]);
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         irq_or_q <= 2'h0;
         irq_q <= 2'h0;
      end
      else
      begin
         irq_or_q <= irq_or_d;
         irq_q[0] <= port_a_irq_rising ? (irq_or_d[0] & ~irq_or_q[0])
                                       : (~irq_or_d[0] & irq_or_q[0]);
         irq_q[1] <= port_b_irq_rising ? (irq_or_d[1] & ~irq_or_q[1])
                                       : (~irq_or_d[1] & irq_or_q[1]);
      end
   end

   // Port connections
   assign cfg_rdata = cfg_rdata_q;
   assign in_rdata = in_rdata_q;
   assign port_a_pin_out = pin_out_q[0];
   assign port_a_pin_oe = pin_oe_q[0];
   assign port_a_pin_pullup = pin_pu_q[0];
   assign port_b_pin_out = pin_out_q[1];
   assign port_b_pin_oe = pin_oe_q[1];
   assign port_b_pin_pullup = pin_pu_q[1];
   assign port_c_pin_out = pin_out_q[2][5:0];
   assign port_c_pin_oe = pin_oe_q[2][5:0];
   assign port_c_pin_pullup = pin_pu_q[2][5:0];
   assign port_a_periph_in = periph_a_q;
   assign port_c_periph_in = periph_c_q;
   assign analog_input_channel = analog_q;
   assign analog_vref_select = vref_q;
   assign port_a_irq = irq_q[0];
   assign port_b_irq = irq_q[1];

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_input_no_drive: assert property ((ddr_q[1] == 8'h00) |=> (port_b_pin_oe == 8'h00))
      else $error("port B drives a pin set as input");
   a_port_c_upper: assert property ((ddr_q[2][7:6] == 2'h0) && (out_q[2][7:6] == 2'h0))
      else $error("port C upper bits became set");
   a_analog_release: assert property ((af_q[1] == 8'hFF) |=> (port_b_pin_oe == 8'h00)
      && (port_b_pin_pullup == 8'h00) && (analog_input_channel == 8'hFF))
      else $error("analog pin still driven");
   a_cfg_readback: assert property ((cfg_rd && cfg_addr == `GPIO_PORT_B_DIRECTION_ADDR)
      |=> (cfg_rdata == $past(ddr_q[1])))
      else $error("direction readback wrong");
   a_output_latch: assert property ((out_wr && out_addr == `GPIO_PORT_B_IO_ADDR)
      |=> (out_q[1] == $past(out_wdata)))
      else $error("output latch not written");
   a_pullup_hold: assert property ((cfg_wr && cfg_addr == `GPIO_PORT_A_PULLUP_ADDR)
      |=> $stable(pu_act_q[0]))
      else $error("pull-up went live without direction write");
   a_pullup_latch: assert property ((cfg_wr && cfg_addr == `GPIO_PORT_A_DIRECTION_ADDR)
      |=> (pu_act_q[0] == $past(pu_q[0])))
      else $error("pull-up not latched on direction write");
   a_readback_output: assert property ((in_rd && in_addr == `GPIO_PORT_A_IO_ADDR)
      |=> (in_rdata == (($past(ddr_q[0]) & $past(out_q[0]))
      | (~$past(ddr_q[0]) & $past(level[0])))))
      else $error("input readback wrong");
   a_irq_pulse: assert property (port_a_irq |=> !port_a_irq)
      else $error("port A request longer than one cycle");
   a_variant_unused: assert property ((PKG_VARIANT != `GPIO_VARIANT_FULL)
      |-> (ddr_q[2] == 8'h00))
      else $error("port C configured in small package");

endmodule

// *** testbench/pin_partner.sv ***
// Pad model: resolves the level the GPIO block sees on each pin
`timescale 1ns/10ps
module pin_partner #(
   parameter int W = 8
)
(
   // Clock
   input wire logic ref_clk,
   // Block drive
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] pull_en,
   // External source
   input wire logic [W-1:0] ext,
   input wire logic [W-1:0] ext_en,
   // Resolved pad
   output logic [W-1:0] pad
);
   logic float_q = 1'b0;
   // A floating pad toggles every cycle, so the synchroniser's agreement filter holds its last level
   always_ff @(posedge ref_clk)
   begin
      float_q <= ~float_q;
   end
   // Block drive wins, then the outside source, then the pull-up
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         pad[i] = oe[i] ? drv[i] : (ext_en[i] ? ext[i] : (pull_en[i] ? 1'b1 : float_q));
      end
   end
endmodule

// *** testbench/tb_three_port_gpio_config.sv ***
// Register-level bench of the three-port GPIO block
`timescale 1ns/10ps
`define CHECK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module tb_three_port_gpio_config;
   logic ref_clk, rst_n, cfg_wr, cfg_rd, in_rd, out_wr, vref, irq_a, irq_b, rise_a, rise_b;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, in_addr, in_rdata, out_addr, out_wdata;
   logic [7:0] pad_a, out_a, oe_a, pu_a, pad_b, out_b, oe_b, pu_b, ext_a, ext_b, en_a, en_b;
   logic [7:0] periph_a, pin_a, analog;
   logic [5:0] pad_c, out_c, oe_c, pu_c, ext_c, en_c, periph_c, pin_c;
   int errors = 0;
   int check_count = 0;
   int irq_a_cnt = 0;
   int irq_b_cnt = 0;

   three_port_gpio_config #(.PKG_VARIANT(0)) three_port_gpio_config_inst (
      .ref_clk(ref_clk), .rst_n(rst_n),
      .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd),
      .cfg_rdata(cfg_rdata), .in_addr(in_addr), .in_rd(in_rd), .in_rdata(in_rdata),
      .out_addr(out_addr), .out_wr(out_wr), .out_wdata(out_wdata),
      .port_a_pin_in(pad_a), .port_a_pin_out(out_a), .port_a_pin_oe(oe_a),
      .port_a_pin_pullup(pu_a), .port_b_pin_in(pad_b), .port_b_pin_out(out_b),
      .port_b_pin_oe(oe_b), .port_b_pin_pullup(pu_b), .port_c_pin_in(pad_c),
      .port_c_pin_out(out_c), .port_c_pin_oe(oe_c), .port_c_pin_pullup(pu_c),
      .port_a_periph_out(periph_a), .port_a_periph_in(pin_a),
      .port_c_periph_out(periph_c), .port_c_periph_in(pin_c),
      .analog_input_channel(analog), .analog_vref_select(vref),
      .port_a_irq_rising(rise_a), .port_b_irq_rising(rise_b),
      .port_a_irq(irq_a), .port_b_irq(irq_b)
   );
   pin_partner #(.W(8)) pin_partner_a_inst (.ref_clk(ref_clk), .oe(oe_a), .drv(out_a),
      .pull_en(pu_a), .ext(ext_a), .ext_en(en_a), .pad(pad_a));
   pin_partner #(.W(8)) pin_partner_b_inst (.ref_clk(ref_clk), .oe(oe_b), .drv(out_b),
      .pull_en(pu_b), .ext(ext_b), .ext_en(en_b), .pad(pad_b));
   pin_partner #(.W(6)) pin_partner_c_inst (.ref_clk(ref_clk), .oe(oe_c), .drv(out_c),
      .pull_en(pu_c), .ext(ext_c), .ext_en(en_c), .pad(pad_c));

   // Free-running clock, 50 ns period
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Interrupt pulses seen per port, one count per high cycle
   always @(posedge ref_clk)
   begin
      if (irq_a === 1'b1)
         irq_a_cnt <= irq_a_cnt + 1;
      if (irq_b === 1'b1)
         irq_b_cnt <= irq_b_cnt + 1;
   end

   task automatic report_and_stop();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic do_reset(input int n);
      @(negedge ref_clk);
      rst_n = 1'b0;
      idle(n);
      rst_n = 1'b1;
   endtask

   task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
   endtask

   task automatic out_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      out_addr = a;
      out_wdata = d;
      out_wr = 1'b1;
      @(negedge ref_clk);
      out_wr = 1'b0;
   endtask

   // Read data holds after the strobe, so sample one cycle later
   task automatic cfg_read(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(negedge ref_clk);
      cfg_rd = 1'b0;
      @(negedge ref_clk);
      `CHECK(cfg_rdata, exp)
   endtask

   task automatic in_read(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      in_addr = a;
      in_rd = 1'b1;
      @(negedge ref_clk);
      in_rd = 1'b0;
      @(negedge ref_clk);
      `CHECK(in_rdata, exp)
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial
   begin
      #200us;
      errors++;
      report_and_stop();
   end

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      {cfg_wr, cfg_rd, in_rd, out_wr, rise_a, rise_b} = 6'h03;
      {cfg_addr, cfg_wdata, in_addr, out_addr, out_wdata} = 40'h0;
      {ext_a, ext_b, periph_a} = 24'h0;
      {en_a, en_b} = 16'hFFFF;
      {ext_c, en_c, periph_c} = 18'h00FC0;
      do_reset(20);
      for (int a = 8'h18; a <= 8'h23; a++)
      begin
         cfg_write(8'(a), 8'hA5);
         cfg_read(8'(a), (a >= 8'h20) ? 8'h25 : 8'hA5);
      end
      cfg_write(8'h24, 8'hFF);
      cfg_read(8'h24, 8'h00);
      // Mid-run reset must clear every configuration register
      do_reset(4);
      for (int a = 8'h18; a <= 8'h23; a++)
         cfg_read(8'(a), 8'h00);
      // Port B split into outputs and inputs
      ext_b = 8'h3C;
      cfg_write(8'h1E, 8'hFF);
      idle(3);
      `CHECK(out_b, 8'h00)
      cfg_write(8'h1E, 8'h0F);
      out_write(8'h01, 8'h5A);
      idle(6);
      `CHECK(oe_b, 8'h0F)
      `CHECK(out_b & 8'h0F, 8'h0A)
      in_read(8'h01, 8'h3A);
      out_write(8'h03, 8'hFF);
      idle(2);
      `CHECK(out_b & 8'h0F, 8'h0A)
      in_read(8'h03, 8'h00);
      // Fresh pin level is not visible before the synchroniser settles
      ext_a = 8'hC3;
      idle(6);
      ext_a = 8'h96;
      in_read(8'h00, 8'hC3);
      idle(6);
      in_read(8'h00, 8'h96);
      // Pull-up on released port C pins waits for a direction write
      en_c = 6'h00;
      cfg_write(8'h20, 8'h3F);
      idle(3);
      `CHECK(pu_c, 6'h00)
      cfg_write(8'h22, 8'h00);
      idle(3);
      `CHECK(pu_c, 6'h3F)
      idle(4);
      in_read(8'h02, 8'h3F);
      // Open drain on pin 0, push-pull on pin 1
      cfg_write(8'h20, 8'h00);
      cfg_write(8'h21, 8'h01);
      cfg_write(8'h22, 8'h03);
      out_write(8'h02, 8'h02);
      idle(3);
      `CHECK(oe_c, 6'h03)
      `CHECK(out_c, 6'h02)
      out_write(8'h02, 8'h01);
      idle(3);
      `CHECK(oe_c, 6'h02)
      `CHECK(out_c, 6'h00)
      // Port C handed to its peripherals
      periph_c = 6'h15;
      cfg_write(8'h23, 8'h3F);
      cfg_write(8'h21, 8'h00);
      cfg_write(8'h22, 8'h3F);
      idle(6);
      `CHECK(out_c, 6'h15)
      `CHECK(pin_c, 6'h15)
      // Port B pins 7 and 0 handed to the converter
      cfg_write(8'h1F, 8'h81);
      idle(3);
      `CHECK(analog, 8'h81)
      `CHECK(vref, 1'b1)
      `CHECK(oe_b, 8'h0E)
      // Interrupt on pin 0 of ports A and B, rising then falling
      cfg_write(8'h1F, 8'h00);
      cfg_write(8'h1D, 8'h01);
      cfg_write(8'h1E, 8'h00);
      cfg_write(8'h19, 8'h01);
      cfg_write(8'h1A, 8'h00);
      idle(8);
      `CHECK(irq_a_cnt + irq_b_cnt, 0)
      ext_a[0] = 1'b1;
      ext_b[0] = 1'b1;
      idle(8);
      `CHECK(irq_a_cnt, 1)
      `CHECK(irq_b_cnt, 1)
      in_read(8'h01, 8'h3D);
      {rise_a, rise_b} = 2'h0;
      idle(2);
      ext_a[0] = 1'b0;
      ext_b[0] = 1'b0;
      idle(8);
      `CHECK(irq_a_cnt, 2)
      `CHECK(irq_b_cnt, 2)
      report_and_stop();
   end
endmodule
